// file: logic/mcad_consts.svh
// mcad_consts.svh: timing counts and counter width for the card host controller
// assumes a 25 MHz system clock
`ifndef MCAD_CONSTS_SVH
`define MCAD_CONSTS_SVH
`define MCAD_CLK_MHZ 25
// strobe width and setup/hold, in ns
`define MCAD_SETUP_NS 80
`define MCAD_STROBE_NS 250
`define MCAD_HOLD_NS 40
`define MCAD_CYC(ns) ((((ns) * `MCAD_CLK_MHZ) + 999) / 1000)
`define MCAD_SETUP_CYC `MCAD_CYC(`MCAD_SETUP_NS)
`define MCAD_STROBE_CYC `MCAD_CYC(`MCAD_STROBE_NS)
`define MCAD_HOLD_CYC `MCAD_CYC(`MCAD_HOLD_NS)
`define MCAD_CNT_W 4
`endif

// file: logic/mcad_pkg.sv
// mcad_pkg.sv: types for the card host controller
// assumes nothing beyond the consts header
`default_nettype none
package mcad_pkg;
    typedef enum logic [1:0] {
        MCAD_MODE_BYTE = 2'h0,
        MCAD_MODE_WORD = 2'h1,
        MCAD_MODE_ODD = 2'h2
    } mcad_mode_t;

    typedef enum logic [1:0] {
        MCAD_OP_MAIN_RD = 2'h0,
        MCAD_OP_MAIN_WR = 2'h1,
        MCAD_OP_MAIN_PGM = 2'h2,
        MCAD_OP_ATTR_RD = 2'h3
    } mcad_op_t;

    typedef struct packed {
        mcad_op_t op;
        mcad_mode_t mode;
        logic [25:0] addr;
        logic [15:0] wdata;
    } mcad_req_t;

    // card pin image; all strobes active low
    typedef struct packed {
        logic reg_n;
        logic ce1_n;
        logic ce2_n;
        logic oe_n;
        logic we_n;
        logic vpp1_prog;
        logic vpp2_prog;
        logic [25:0] addr;
    } mcad_pins_t;
endpackage : mcad_pkg
`default_nettype wire

// file: logic/mcad_host.sv
// mcad_host.sv: host controller driving a memory card's access pins
// assumes the card data bus is resolved outside from d_out/d_oe; no real clock on the card
//
// How it works
// - main writes use select, enables and A0 exactly as main reads do
// - every main write holds output enable high and pulses write enable low
// - byte, word and odd-only modes pick enables and data lanes
// - programming drives the same control pins as a static RAM write
// - byte program, odd address: VPP2 at program level, VPP1 normal
// - byte program, even address: VPP1 at program level, VPP2 normal
// - odd-only program: VPP2 at program level, VPP1 normal, A0 free
// - word program: both VPP supplies at program level throughout
// - attribute read holds select low and write enable high, and pulses output enable low in the strobe only
// - main read holds select high and pulses output enable low in the strobe only
`include "mcad_consts.svh"
`default_nettype none
module mcad_host #(
    parameter int ADDR_W = 26
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire mcad_pkg::mcad_req_t req,
    output logic req_ready,
    output logic done,
    output logic [15:0] rdata,
    output var mcad_pkg::mcad_pins_t pins,
    output logic [15:0] d_out,
    output logic [1:0] d_oe,
    input wire logic [15:0] d_in
);
    import mcad_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [1:0] {
        MCAD_ST_IDLE = 2'h0,
        MCAD_ST_SETUP = 2'h1,
        MCAD_ST_STROBE = 2'h2,
        MCAD_ST_HOLD = 2'h3
    } mcad_state_t;

    localparam logic [`MCAD_CNT_W-1:0] SETUP_C = `MCAD_CNT_W'(`MCAD_SETUP_CYC);
    localparam logic [`MCAD_CNT_W-1:0] STROBE_C = `MCAD_CNT_W'(`MCAD_STROBE_CYC);
    localparam logic [`MCAD_CNT_W-1:0] HOLD_C = `MCAD_CNT_W'(`MCAD_HOLD_CYC);

    mcad_state_t state_reg;
    logic [`MCAD_CNT_W-1:0] cnt_reg;
    mcad_req_t cur_reg;
    logic [15:0] din_s1_reg;
    logic [15:0] din_s2_reg;
    logic [15:0] din_s3_reg;
    logic [15:0] din_flt_reg;

    function automatic logic is_read(input mcad_op_t op);
        is_read = (op == MCAD_OP_MAIN_RD) || (op == MCAD_OP_ATTR_RD);
    endfunction : is_read

    // ----------------------------------------
    // read data synchroniser
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            din_s1_reg <= 16'h0000;
            din_s2_reg <= 16'h0000;
            din_s3_reg <= 16'h0000;
            din_flt_reg <= 16'h0000;
        end else begin
            din_s1_reg <= d_in;
            din_s2_reg <= din_s1_reg;
            din_s3_reg <= din_s2_reg;
            // a bit moves only once stages two and three agree
            din_flt_reg <= (din_s2_reg & din_s3_reg) | (din_flt_reg & (din_s2_reg | din_s3_reg));
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= MCAD_ST_IDLE;
            cnt_reg <= '0;
            cur_reg <= '0;
            req_ready <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            case (state_reg)
                MCAD_ST_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        cur_reg <= req;
                        // attribute space is byte wide: force byte mode, even address
                        if (req.op == MCAD_OP_ATTR_RD) begin
                            cur_reg.mode <= MCAD_MODE_BYTE;
                            cur_reg.addr[0] <= 1'b0;
                        end
                        req_ready <= 1'b0;
                        cnt_reg <= SETUP_C;
                        state_reg <= MCAD_ST_SETUP;
                    end
                end
                MCAD_ST_SETUP: begin
                    if (cnt_reg <= 1) begin
                        cnt_reg <= STROBE_C;
                        state_reg <= MCAD_ST_STROBE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                MCAD_ST_STROBE: begin
                    if (cnt_reg <= 1) begin
                        cnt_reg <= HOLD_C;
                        state_reg <= MCAD_ST_HOLD;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                MCAD_ST_HOLD: begin
                    if (cnt_reg <= 1) begin
                        done <= 1'b1;
                        state_reg <= MCAD_ST_IDLE;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                default: begin
                    state_reg <= MCAD_ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // card pins
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pins <= '{reg_n: 1'b1, ce1_n: 1'b1, ce2_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                      vpp1_prog: 1'b0, vpp2_prog: 1'b0, addr: '0};
        end else if (state_reg == MCAD_ST_IDLE) begin
            // strobe already high in hold; enables rise a cycle later, address keeps its value
            pins <= '{reg_n: 1'b1, ce1_n: 1'b1, ce2_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                      vpp1_prog: 1'b0, vpp2_prog: 1'b0, addr: pins.addr};
        end else begin
            pins.addr <= cur_reg.addr;
            pins.reg_n <= (cur_reg.op != MCAD_OP_ATTR_RD);
            pins.ce1_n <= (cur_reg.mode == MCAD_MODE_ODD);
            pins.ce2_n <= (cur_reg.mode == MCAD_MODE_BYTE);
            pins.oe_n <= !(is_read(cur_reg.op) && state_reg == MCAD_ST_STROBE);
            pins.we_n <= !(!is_read(cur_reg.op) && state_reg == MCAD_ST_STROBE);
            if (cur_reg.op == MCAD_OP_MAIN_PGM) begin
                case (cur_reg.mode)
                    MCAD_MODE_WORD: begin
                        pins.vpp1_prog <= 1'b1;
                        pins.vpp2_prog <= 1'b1;
                    end
                    MCAD_MODE_ODD: begin
                        pins.vpp1_prog <= 1'b0;
                        pins.vpp2_prog <= 1'b1;
                    end
                    default: begin
                        pins.vpp1_prog <= !cur_reg.addr[0];
                        pins.vpp2_prog <= cur_reg.addr[0];
                    end
                endcase
            end else begin
                pins.vpp1_prog <= 1'b0;
                pins.vpp2_prog <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // data lanes and read capture
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            d_out <= 16'h0000;
            d_oe <= 2'h0;
        end else if (!is_read(cur_reg.op) && state_reg != MCAD_ST_IDLE) begin
            // write data stands through hold, past the rising write strobe
            case (cur_reg.mode)
                MCAD_MODE_WORD: begin
                    d_out <= cur_reg.wdata;
                    d_oe <= 2'h3;
                end
                MCAD_MODE_ODD: begin
                    d_out <= {cur_reg.wdata[15:8], 8'h00};
                    d_oe <= 2'h2;
                end
                default: begin
                    d_out <= {8'h00, cur_reg.wdata[7:0]};
                    d_oe <= 2'h1;
                end
            endcase
        end else begin
            d_out <= 16'h0000;
            d_oe <= 2'h0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 16'h0000;
        end else if (state_reg == MCAD_ST_HOLD && cnt_reg <= 1 && is_read(cur_reg.op)) begin
            if (cur_reg.op == MCAD_OP_ATTR_RD) begin
                rdata <= {8'h00, din_flt_reg[7:0]};
            end else if (cur_reg.mode == MCAD_MODE_BYTE) begin
                rdata <= {8'h00, din_flt_reg[7:0]};
            end else if (cur_reg.mode == MCAD_MODE_ODD) begin
                rdata <= {din_flt_reg[15:8], 8'h00};
            end else begin
                rdata <= din_flt_reg;
            end
        end
    end
endmodule : mcad_host
`default_nettype wire

// file: verification/mcad_card_model.sv
// mcad_card_model.sv: behavioural memory card answering the host controller
// assumes the bench resolves the data lanes from both parties' enables
`default_nettype none
module mcad_card_model (
    input wire mcad_pkg::mcad_pins_t pins,
    input wire logic [15:0] d,
    output wire logic [15:0] cd,
    output logic [1:0] coe
);
    import mcad_pkg::*;
    logic [7:0] mem [0:31];
    logic [4:0] a;
    logic sel;
    logic rd;
    logic ok;
    assign a = pins.addr[4:0];
    assign sel = !pins.ce1_n || !pins.ce2_n;
    assign rd = sel && !pins.oe_n && pins.we_n;
    // programming refused unless supplies fit the lanes
    always_comb begin
        case ({pins.ce2_n, pins.ce1_n})
            2'h2: ok = {pins.vpp2_prog, pins.vpp1_prog} == {a[0], !a[0]};
            2'h1: ok = {pins.vpp2_prog, pins.vpp1_prog} == 2'h2;
            default: ok = {pins.vpp2_prog, pins.vpp1_prog} == 2'h3;
        endcase
        ok = ok || !(pins.vpp1_prog || pins.vpp2_prog);
    end
    always @(posedge pins.we_n) begin
        if (sel && pins.reg_n && ok) begin
            if (!pins.ce1_n) mem[pins.ce2_n ? a : {a[4:1], 1'b0}] <= d[7:0];
            if (!pins.ce2_n) mem[{a[4:1], 1'b1}] <= d[15:8];
        end
    end
    assign coe = rd ? {!pins.ce2_n, !pins.ce1_n} : 2'h0;
    assign cd[7:0] = !pins.reg_n ? {3'h5, a} ^ {8{a[0]}} :
                     mem[pins.ce2_n ? a : {a[4:1], 1'b0}];
    assign cd[15:8] = !pins.reg_n ? ~{3'h5, a} : mem[{a[4:1], 1'b1}];
endmodule : mcad_card_model
`default_nettype wire

// file: verification/mcad_host_chk.sv
// mcad_host_chk.sv: pin-level assertions for the card host controller
// assumes it is bound to mcad_host and sees only its ports
`default_nettype none
module mcad_host_chk (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire mcad_pkg::mcad_req_t req,
    input wire logic req_ready,
    input wire logic done,
    input wire logic [15:0] rdata,
    input wire mcad_pkg::mcad_pins_t pins,
    input wire logic [15:0] d_out,
    input wire logic [1:0] d_oe,
    input wire logic [15:0] d_in
);
    import mcad_pkg::*;
    logic wr;
    logic vp;
    assign wr = !pins.we_n;
    assign vp = pins.vpp1_prog || pins.vpp2_prog;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wr_oe_high_a: assert property (wr |-> pins.oe_n && pins.reg_n) else $error("oe low in write");
    wr_lanes_a: assert property (wr |-> d_oe == {!pins.ce2_n, !pins.ce1_n}) else $error("lanes");
    vpp_byte_a: assert property (wr && vp && pins.ce2_n |-> {pins.vpp2_prog, pins.vpp1_prog}
        == {pins.addr[0], !pins.addr[0]}) else $error("byte vpp");
    vpp_odd_a: assert property (wr && vp && pins.ce1_n |-> pins.vpp2_prog && !pins.vpp1_prog)
        else $error("odd vpp");
    vpp_word_a: assert property (wr && vp && !pins.ce1_n && !pins.ce2_n |->
        pins.vpp2_prog && pins.vpp1_prog) else $error("word vpp");
    vpp_pgm_only_a: assert property (vp |-> pins.oe_n) else $error("vpp in read");
    attr_rd_a: assert property (!pins.reg_n |-> pins.we_n && pins.ce2_n && !pins.ce1_n
        && !pins.addr[0]) else $error("attr read pins");
    rd_float_a: assert property (!pins.oe_n |-> pins.we_n && d_oe == 2'h0) else $error("rd drive");
    wr_hold_a: assert property ($fell(pins.we_n) |-> $stable({pins.ce1_n, pins.ce2_n,
        pins.addr, d_out})[*8]) else $error("write pins moved");
    rd_hold_a: assert property ($fell(pins.oe_n) |-> !pins.oe_n[*7] ##1 pins.oe_n)
        else $error("read strobe width");
    cover property ($fell(pins.we_n) && vp);
    cover property ($fell(pins.oe_n) && !pins.reg_n);
    cover property ($fell(pins.we_n) && !pins.ce1_n && !pins.ce2_n);
endmodule : mcad_host_chk
bind mcad_host mcad_host_chk chk (.sys_clk, .reset_n, .req_valid, .req, .req_ready, .done,
    .rdata, .pins, .d_out, .d_oe, .d_in);
`default_nettype wire

// file: verification/memory_card_access_decode_bench.sv
// memory_card_access_decode_bench.sv: bench for the card host controller
// assumes the card model and the bound checker
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module memory_card_access_decode_bench import mcad_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, reset_n = 0, req_valid = 0;
    mcad_req_t req = '0;
    logic req_ready, done;
    logic [15:0] rdata, d_out, cd, r;
    wire logic [15:0] d_in;
    logic [1:0] d_oe, coe;
    mcad_pins_t pins;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    assign d_in[7:0] = coe[0] ? cd[7:0] : d_oe[0] ? d_out[7:0] : ~cd[7:0];
    assign d_in[15:8] = coe[1] ? cd[15:8] : d_oe[1] ? d_out[15:8] : ~cd[15:8];
    mcad_host dut (.sys_clk, .reset_n, .req_valid, .req, .req_ready, .done, .rdata, .pins,
        .d_out, .d_oe, .d_in);
    mcad_card_model card (.pins, .d(d_in), .cd, .coe);
    initial forever #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic acc(input mcad_op_t op, input mcad_mode_t md, input logic [25:0] a,
        input logic [15:0] w);
        int k;
        k = 0;
        #1 req_valid = 1;
        req = '{op, md, a, w};
        while (req_ready !== 1'b1) @(posedge sys_clk) #1;
        @(posedge sys_clk) #1 req_valid = 0;
        `CHK("busy", 1'b0, req_ready)
        while (done !== 1'b1 && k < 40) begin
            @(posedge sys_clk) #1;
            k++;
        end
        `CHK("done", 1'b1, done)
        r = rdata;
        @(posedge sys_clk);
    endtask : acc
    task automatic t_write;
        acc(MCAD_OP_MAIN_WR, MCAD_MODE_WORD, 26'h2, 16'hBEEF);
        acc(MCAD_OP_MAIN_WR, MCAD_MODE_BYTE, 26'h5, 16'h0011);
        acc(MCAD_OP_MAIN_WR, MCAD_MODE_ODD, 26'h6, 16'h2200);
        acc(MCAD_OP_MAIN_RD, MCAD_MODE_WORD, 26'h2, 16'h0);
        `CHK("word rd", 16'hBEEF, r)
        acc(MCAD_OP_MAIN_RD, MCAD_MODE_WORD, 26'h4, 16'h0);
        `CHK("odd byte wr", 8'h11, r[15:8])
        acc(MCAD_OP_MAIN_RD, MCAD_MODE_BYTE, 26'h3, 16'h0);
        `CHK("byte rd odd", 8'hBE, r[7:0])
        acc(MCAD_OP_MAIN_RD, MCAD_MODE_ODD, 26'h6, 16'h0);
        `CHK("odd only rd", 8'h22, r[15:8])
        $display("test write done");
    endtask : t_write
    task automatic t_pgm;
        acc(MCAD_OP_MAIN_PGM, MCAD_MODE_BYTE, 26'h8, 16'h0033);
        acc(MCAD_OP_MAIN_PGM, MCAD_MODE_BYTE, 26'h9, 16'h0044);
        acc(MCAD_OP_MAIN_PGM, MCAD_MODE_WORD, 26'hA, 16'h6655);
        acc(MCAD_OP_MAIN_PGM, MCAD_MODE_ODD, 26'hC, 16'h7700);
        acc(MCAD_OP_MAIN_RD, MCAD_MODE_WORD, 26'h8, 16'h0);
        `CHK("pgm bytes", 16'h4433, r)
        acc(MCAD_OP_MAIN_RD, MCAD_MODE_WORD, 26'hA, 16'h0);
        `CHK("pgm word", 16'h6655, r)
        acc(MCAD_OP_MAIN_RD, MCAD_MODE_WORD, 26'hC, 16'h0);
        `CHK("pgm odd", 8'h77, r[15:8])
        $display("test program done");
    endtask : t_pgm
    task automatic t_attr;
        acc(MCAD_OP_ATTR_RD, MCAD_MODE_BYTE, 26'h8, 16'h0);
        `CHK("attr even", 8'hA8, r[7:0])
        acc(MCAD_OP_ATTR_RD, MCAD_MODE_WORD, 26'h15, 16'h0);
        `CHK("attr forced", 8'hB4, r[7:0])
        $display("test attribute done");
    endtask : t_attr
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 reset_n = 1;
        @(posedge sys_clk);
        t_write();
        t_pgm();
        t_attr();
        print_verdict();
    end
endmodule : memory_card_access_decode_bench
`default_nettype wire
